// File: core/prim_asm_pkg.sv
package prim_asm_pkg;
  localparam int VTX_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int MODE_W = 3;
  localparam int KIND_W = 2;
  localparam logic [2:0] MODE_POINTS = 3'h0;
  localparam logic [2:0] MODE_STRIP = 3'h1;
  localparam logic [2:0] MODE_LOOP = 3'h2;
  localparam logic [2:0] MODE_PAIRS = 3'h3;
  localparam logic [2:0] MODE_POLYGON = 3'h4;
  localparam logic [2:0] MODE_TRISTRIP = 3'h5;
  localparam logic [1:0] KIND_POINT = 2'h0;
  localparam logic [1:0] KIND_LINE = 2'h1;
  localparam logic [1:0] KIND_TRI = 2'h2;
  localparam int PRIM_W = 3 * VTX_W + KIND_W;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_CLOSE = 2'b10
  } asm_state_t;
endpackage

// File: core/prim_fifo.sv
// queue module is kept with the assembler logic

// File: core/primitive_assembler.sv
`timescale 1ns/1ps
module primitive_assembler (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic vtx_valid,
  output logic vtx_ready,
  input wire logic [prim_asm_pkg::VTX_W-1:0] vtx_data,
  input wire logic vtx_last,
  input wire logic [prim_asm_pkg::MODE_W-1:0] vtx_mode,
  output logic prim_valid,
  input wire logic prim_ready,
  output logic [prim_asm_pkg::KIND_W-1:0] prim_kind,
  output logic [prim_asm_pkg::VTX_W-1:0] prim_v0,
  output logic [prim_asm_pkg::VTX_W-1:0] prim_v1,
  output logic [prim_asm_pkg::VTX_W-1:0] prim_v2
);
  localparam int VW = prim_asm_pkg::VTX_W;
  localparam int PW = prim_asm_pkg::PRIM_W;
  localparam int OW = $clog2(prim_asm_pkg::FIFO_DEPTH) + 1;

  prim_asm_pkg::asm_state_t state_ff;
  logic [VW-1:0] slot_a_ff;
  logic [VW-1:0] slot_b_ff;
  logic first_ff;
  logic second_ff;
  logic ptr_ff;
  logic parity_ff;
  logic [VW-1:0] out_v0_ff;
  logic [VW-1:0] out_v1_ff;
  logic [VW-1:0] out_v2_ff;
  logic [prim_asm_pkg::KIND_W-1:0] out_kind_ff;
  logic out_valid_ff;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [PW-1:0] fifo_out_data;
  logic [PW-1:0] emit_data;
  logic emit;
  logic take;
  logic stall;
  logic [VW-1:0] close_v_ff;
  logic close_ok_ff;
  logic vtx_ready_ff;
  logic [OW-1:0] occ_ff;
  logic [OW-1:0] nxt_occ;
  logic fifo_pop_ready;
  logic pop;
  logic close_start;
  logic nxt_run;

  // output register stage drains the fifo
  assign stall = !fifo_in_ready;
  assign vtx_ready = vtx_ready_ff;
  assign take = vtx_valid && vtx_ready;

  function automatic logic mode_is_loop(input logic [prim_asm_pkg::MODE_W-1:0] m);
    mode_is_loop = (m == prim_asm_pkg::MODE_LOOP);
  endfunction
  assign close_start = take && vtx_last && mode_is_loop(vtx_mode);
  assign fifo_pop_ready = !out_valid_ff || prim_ready;
  assign pop = fifo_out_valid && fifo_pop_ready;
  // ready is registered, so it is worked out one cycle ahead
  assign nxt_run = ((state_ff == prim_asm_pkg::ST_RUN) && !close_start)
    || ((state_ff == prim_asm_pkg::ST_CLOSE) && !stall);

  // combinational decode of what the accepted vertex or the loop closing cycle emits
  logic [prim_asm_pkg::KIND_W-1:0] nxt_kind;
  logic [VW-1:0] nxt_e0;
  logic [VW-1:0] nxt_e1;
  logic [VW-1:0] nxt_e2;
  logic nxt_emit;
  always_comb begin
    nxt_emit = 1'b0;
    nxt_kind = prim_asm_pkg::KIND_POINT;
    nxt_e0 = vtx_data;
    nxt_e1 = vtx_data;
    nxt_e2 = vtx_data;
    if (state_ff == prim_asm_pkg::ST_CLOSE) begin
      nxt_emit = close_ok_ff;
      nxt_kind = prim_asm_pkg::KIND_LINE;
      nxt_e0 = close_v_ff;
      nxt_e1 = slot_a_ff;
      nxt_e2 = slot_a_ff;
    end else if (take) begin
      case (vtx_mode)
        prim_asm_pkg::MODE_POINTS: begin
          nxt_emit = 1'b1;
        end
        prim_asm_pkg::MODE_STRIP, prim_asm_pkg::MODE_LOOP: begin
          nxt_emit = !first_ff;
          nxt_kind = prim_asm_pkg::KIND_LINE;
          nxt_e0 = slot_b_ff;
        end
        prim_asm_pkg::MODE_PAIRS: begin
          nxt_emit = parity_ff;
          nxt_kind = prim_asm_pkg::KIND_LINE;
          nxt_e0 = slot_a_ff;
        end
        prim_asm_pkg::MODE_POLYGON: begin
          nxt_emit = !first_ff && !second_ff;
          nxt_kind = prim_asm_pkg::KIND_TRI;
          nxt_e0 = slot_a_ff;
          nxt_e1 = slot_b_ff;
        end
        prim_asm_pkg::MODE_TRISTRIP: begin
          nxt_emit = !first_ff && !second_ff;
          nxt_kind = prim_asm_pkg::KIND_TRI;
          nxt_e0 = slot_a_ff;
          nxt_e1 = slot_b_ff;
        end
        default: begin
          nxt_emit = 1'b0;
        end
      endcase
    end
  end
  assign emit = nxt_emit && !stall;
  assign emit_data = {nxt_kind, nxt_e0, nxt_e1, nxt_e2};
  assign nxt_occ = occ_ff + OW'(emit) - OW'(pop);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= prim_asm_pkg::ST_RUN;
      close_v_ff <= '0;
      close_ok_ff <= 1'b0;
    end else begin
      case (state_ff)
        prim_asm_pkg::ST_RUN: begin
          if (close_start) begin
            state_ff <= prim_asm_pkg::ST_CLOSE;
            close_v_ff <= vtx_data;
            close_ok_ff <= !first_ff;
          end
        end
        prim_asm_pkg::ST_CLOSE: begin
          if (!stall) begin
            state_ff <= prim_asm_pkg::ST_RUN;
          end
        end
        default: begin
          state_ff <= prim_asm_pkg::ST_RUN;
        end
      endcase
    end
  end

  // vertex memory: slot a holds first/start, slot b the previous vertex; tristrip alternates vertices between slot a and slot b
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      slot_a_ff <= '0;
      slot_b_ff <= '0;
      first_ff <= 1'b1;
      second_ff <= 1'b1;
      ptr_ff <= 1'b0;
      parity_ff <= 1'b0;
    end else if (take) begin
      first_ff <= vtx_last;
      second_ff <= vtx_last || first_ff;
      case (vtx_mode)
        prim_asm_pkg::MODE_STRIP, prim_asm_pkg::MODE_LOOP: begin
          slot_b_ff <= vtx_data;
          if (first_ff) begin
            slot_a_ff <= vtx_data;
          end
        end
        prim_asm_pkg::MODE_PAIRS: begin
          parity_ff <= vtx_last ? 1'b0 : !parity_ff;
          if (!parity_ff) begin
            slot_a_ff <= vtx_data;
          end
        end
        prim_asm_pkg::MODE_POLYGON: begin
          slot_b_ff <= vtx_data;
          if (first_ff) begin
            slot_a_ff <= vtx_data;
          end
        end
        prim_asm_pkg::MODE_TRISTRIP: begin
          ptr_ff <= vtx_last ? 1'b0 : !ptr_ff;
          if (!ptr_ff) begin
            slot_a_ff <= vtx_data;
          end else begin
            slot_b_ff <= vtx_data;
          end
        end
        default: begin
          slot_b_ff <= slot_b_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      occ_ff <= '0;
      vtx_ready_ff <= 1'b1;
    end else begin
      occ_ff <= nxt_occ;
      vtx_ready_ff <= nxt_run && (nxt_occ != OW'(prim_asm_pkg::FIFO_DEPTH));
    end
  end

  prim_fifo #(
    .WIDTH(PW),
    .DEPTH(prim_asm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(emit),
    .in_ready(fifo_in_ready),
    .in_data(emit_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_ff <= 1'b0;
      out_kind_ff <= prim_asm_pkg::KIND_POINT;
      out_v0_ff <= '0;
      out_v1_ff <= '0;
      out_v2_ff <= '0;
    end else if (!out_valid_ff || prim_ready) begin
      out_valid_ff <= fifo_out_valid;
      if (fifo_out_valid) begin
        {out_kind_ff, out_v0_ff, out_v1_ff, out_v2_ff} <= fifo_out_data;
      end
    end
  end

  assign prim_valid = out_valid_ff;
  assign prim_kind = out_kind_ff;
  assign prim_v0 = out_v0_ff;
  assign prim_v1 = out_v1_ff;
  assign prim_v2 = out_v2_ff;
endmodule

module prim_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic do_wr;
  logic do_rd;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
      end
      if (do_rd) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
      end
      count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// File: tb/primitive_assembler_properties.sv
`timescale 1ns/1ps
module primitive_assembler_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic vtx_valid,
  input wire logic vtx_ready,
  input wire logic vtx_last,
  input wire logic [2:0] vtx_mode,
  input wire logic prim_valid,
  input wire logic prim_ready,
  input wire logic [1:0] prim_kind,
  input wire logic [31:0] prim_v0,
  input wire logic [31:0] prim_v1,
  input wire logic [31:0] prim_v2
);
  logic [5:0] idle_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence take_s; vtx_valid && vtx_ready; endsequence
  sequence pt_take_s; take_s ##0 vtx_mode == prim_asm_pkg::MODE_POINTS; endsequence
  sequence close_take_s; take_s ##0 vtx_last && vtx_mode == prim_asm_pkg::MODE_LOOP; endsequence
  // idle cycles with the sink accepting
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) idle_ff <= 6'h00;
    else if ((vtx_valid && vtx_ready) || !prim_ready) idle_ff <= 6'h00;
    else if (idle_ff != 6'h28) idle_ff <= idle_ff + 6'h01;
  end
  AST_HOLD: assert property (prim_valid && !prim_ready |=> prim_valid && $stable(prim_kind) && $stable(prim_v0)
    && $stable(prim_v1) && $stable(prim_v2)) else $error("output changed while stalled");
  AST_POINT_SHAPE: assert property (prim_valid && prim_kind == prim_asm_pkg::KIND_POINT |-> prim_v0 == prim_v1
    && prim_v1 == prim_v2) else $error("point vertices differ");
  AST_LINE_SHAPE: assert property (prim_valid && prim_kind == prim_asm_pkg::KIND_LINE |-> prim_v2 == prim_v1)
    else $error("line v2 not v1");
  AST_KIND_LEGAL: assert property (prim_valid |-> prim_kind != 2'h3) else $error("bad kind");
  AST_POINT_EMIT: assert property (pt_take_s |-> ##[2:40] prim_valid) else $error("point not emitted");
  AST_READY_RELEASE: assert property (!$past(reset_n) |-> vtx_ready) else $error("not ready after reset");
  AST_READY_FALL: assert property ($fell(vtx_ready) |-> $past(vtx_valid)) else $error("refused without a take");
  AST_DRAIN: assert property (idle_ff == 6'h28 |-> !prim_valid) else $error("output not drained");
  AST_CLOSE_REFUSE: assert property (close_take_s |=> !vtx_ready) else $error("no closing cycle");
endmodule
bind primitive_assembler primitive_assembler_properties i_primitive_assembler_properties (.clock(clock),
  .reset_n(reset_n), .vtx_valid(vtx_valid), .vtx_ready(vtx_ready), .vtx_last(vtx_last), .vtx_mode(vtx_mode),
  .prim_valid(prim_valid),
  .prim_ready(prim_ready), .prim_kind(prim_kind), .prim_v0(prim_v0), .prim_v1(prim_v1), .prim_v2(prim_v2));

// File: tb/primitive_assembler_tb.sv
`timescale 1ns/1ps
module primitive_assembler_tb;
  localparam int PW = prim_asm_pkg::PRIM_W;
  logic clock, reset_n, prim_ready, vtx_valid, vtx_ready, vtx_last, prim_valid;
  logic [31:0] vtx_data, prim_v0, prim_v1, prim_v2;
  logic [2:0] vtx_mode;
  logic [1:0] prim_kind;
  logic [PW-1:0] got[$], exp[$];
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  primitive_assembler i_primitive_assembler (.clock(clock), .reset_n(reset_n), .vtx_valid(vtx_valid),
    .vtx_ready(vtx_ready), .vtx_data(vtx_data), .vtx_last(vtx_last), .vtx_mode(vtx_mode), .prim_valid(prim_valid),
    .prim_ready(prim_ready), .prim_kind(prim_kind), .prim_v0(prim_v0), .prim_v1(prim_v1), .prim_v2(prim_v2));
  vertex_source i_vertex_source (.clock(clock), .vtx_ready(vtx_ready), .vtx_valid(vtx_valid),
    .vtx_data(vtx_data), .vtx_last(vtx_last), .vtx_mode(vtx_mode));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (prim_valid === 1'b1 && prim_ready === 1'b1) got.push_back({prim_kind, prim_v0, prim_v1, prim_v2});
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [PW-1:0] seen, input logic [PW-1:0] want, input string what);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, seen, want);
    end
  endtask
  function automatic logic [31:0] v(input int i);
    return 32'h0000A000 + 32'(i);
  endfunction
  function automatic void e(input logic [1:0] k, input int a, input int b, input int c);
    exp.push_back({k, v(a), v(b), v(c)});
  endfunction
  task automatic batch(input logic [2:0] m, input int n, input int b);
    for (int i = 0; i < n; i++) i_vertex_source.send(v(b + i), i == n - 1, m);
    i_vertex_source.idle();
  endtask
  task automatic done(input string name);
    int w;
    w = 0;
    while (got.size() < exp.size() && w < 300) begin
      @(posedge clock);
      w++;
    end
    repeat (45) @(posedge clock);
    chk(PW'(got.size()), PW'(exp.size()), "count");
    for (int i = 0; i < exp.size() && i < got.size(); i++) chk(got[i], exp[i], "prim");
    got.delete();
    exp.delete();
    $display("test %s done", name);
  endtask
  task automatic t_points();
    for (int i = 0; i < 4; i++) e(prim_asm_pkg::KIND_POINT, i, i, i);
    batch(prim_asm_pkg::MODE_POINTS, 4, 0);
    batch(3'h7, 3, 5);
    done("points");
  endtask
  task automatic t_strip();
    for (int i = 11; i < 14; i++) e(prim_asm_pkg::KIND_LINE, i - 1, i, i);
    batch(prim_asm_pkg::MODE_STRIP, 1, 0);
    batch(prim_asm_pkg::MODE_STRIP, 4, 10);
    done("strip");
  endtask
  task automatic t_loop();
    e(prim_asm_pkg::KIND_LINE, 20, 21, 21);
    e(prim_asm_pkg::KIND_LINE, 21, 22, 22);
    e(prim_asm_pkg::KIND_LINE, 22, 20, 20);
    e(prim_asm_pkg::KIND_LINE, 30, 31, 31);
    e(prim_asm_pkg::KIND_LINE, 31, 30, 30);
    batch(prim_asm_pkg::MODE_LOOP, 3, 20);
    batch(prim_asm_pkg::MODE_LOOP, 2, 30);
    done("loop");
  endtask
  task automatic t_pairs();
    e(prim_asm_pkg::KIND_LINE, 40, 41, 41);
    e(prim_asm_pkg::KIND_LINE, 42, 43, 43);
    e(prim_asm_pkg::KIND_LINE, 60, 61, 61);
    batch(prim_asm_pkg::MODE_PAIRS, 5, 40);
    batch(prim_asm_pkg::MODE_PAIRS, 2, 60);
    done("pairs");
  endtask
  task automatic t_polygon();
    for (int i = 82; i < 85; i++) e(prim_asm_pkg::KIND_TRI, 80, i - 1, i);
    batch(prim_asm_pkg::MODE_POLYGON, 2, 70);
    batch(prim_asm_pkg::MODE_POLYGON, 5, 80);
    done("polygon");
  endtask
  task automatic t_tristrip();
    for (int i = 102; i < 106; i++) begin
      if (i % 2 == 0) e(prim_asm_pkg::KIND_TRI, i - 2, i - 1, i);
      else e(prim_asm_pkg::KIND_TRI, i - 1, i - 2, i);
    end
    batch(prim_asm_pkg::MODE_TRISTRIP, 2, 90);
    batch(prim_asm_pkg::MODE_TRISTRIP, 6, 100);
    done("tristrip");
  endtask
  task automatic t_stall();
    for (int i = 120; i < 132; i++) e(prim_asm_pkg::KIND_POINT, i, i, i);
    prim_ready <= 1'b0;
    fork
      batch(prim_asm_pkg::MODE_POINTS, 12, 120);
      begin
        repeat (40) @(posedge clock);
        chk(PW'(vtx_ready), PW'(0), "refuse");
        prim_ready <= 1'b1;
      end
    join
    done("stall");
  endtask
  initial begin
    reset_n = 1'b0;
    prim_ready = 1'b1;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_points();
    t_strip();
    t_loop();
    t_pairs();
    t_polygon();
    t_tristrip();
    t_stall();
    end_sim();
  end
endmodule

// File: tb/vertex_source.sv
`timescale 1ns/1ps
module vertex_source (
  input wire logic clock,
  input wire logic vtx_ready,
  output logic vtx_valid = 1'b0,
  output logic [31:0] vtx_data = 32'h00000000,
  output logic vtx_last = 1'b0,
  output logic [2:0] vtx_mode = 3'h0
);
  logic rdy_s;
  // ready as it stands before the next edge
  always @(negedge clock) rdy_s = vtx_ready;
  task automatic send(input logic [31:0] d, input logic l, input logic [2:0] m);
    vtx_valid <= 1'b1;
    vtx_data <= d;
    vtx_last <= l;
    vtx_mode <= m;
    do @(posedge clock); while (!rdy_s);
  endtask
  task automatic idle();
    vtx_valid <= 1'b0;
    vtx_data <= ~vtx_data;
    vtx_last <= ~vtx_last;
    @(posedge clock);
  endtask
endmodule
